// ### bench/pio_pin_partner.sv
// External devices and wiring on the port pins
module pio_pin_partner (
  input wire logic clk_sys, // clock
  input wire logic [63:0] pin_out, // block level
  input wire logic [63:0] pin_oe, // block drives
  input wire logic [63:0] pull_en, // pull-up on
  input wire logic [63:0] ext_en, // device drives
  input wire logic [63:0] ext_val, // device level
  output logic [63:0] pin_in // wire level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] noise = 64'h5A5A_A5A5_3C3C_C3C3;
  // Floating pins flip every cycle so a stale value can never pass
  always @(posedge clk_sys) noise <= ~noise;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pull_en | noise));
endmodule : pio_pin_partner

// ### bench/pio_top_monitor.sv
// Assertion checker for the programmable I/O port block
module pio_top_monitor (
  input wire logic clk_sys, // clock
  input wire logic resetn, // reset
  input wire logic [7:0] addr, // addr
  input wire logic [7:0] wdata, // wdata
  input wire logic wr, // write
  input wire logic rd, // read
  input wire logic [7:0] rdata, // rdata
  input wire logic [1:0] proc_mode, // mode
  input wire logic bus_8bit, // width
  input wire logic [63:0] pin_in, // pins
  input wire logic [63:0] periph_en, // owner
  input wire logic [63:0] periph_dat, // level
  input wire logic [63:0] pin_out, // drive
  input wire logic [63:0] pin_oe, // enable
  input wire logic [63:0] pull_en // pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic live;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Masks the first edge after reset, where outputs still hold reset values
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      live <= 1'h0;
    end else begin
      live <= 1'h1;
    end
  end
  AST_RESET_IDLE: assert property (!live |-> pin_oe == '0)
    else $error("pin driven at reset");
  AST_PERIPH_OE: assert property (live |-> (pin_oe & $past(periph_en)) == $past(periph_en))
    else $error("peripheral pin not driven");
  AST_PERIPH_OUT: assert property (live |-> ((pin_out ^ $past(periph_dat)) & $past(periph_en)) == '0)
    else $error("peripheral level lost");
  AST_PULL_INPUT: assert property ((pull_en & pin_oe) == '0)
    else $error("pull-up on output pin");
  AST_BUS_PULL: assert property (live && ($past(proc_mode) inside {2'h1, 2'h2}) |-> pull_en[47:0] == '0)
    else $error("bus port pull-up active");
  AST_DIR_WRITE: assert property (wr && addr == 8'h10 |=> pin_oe[7:0] == ($past(wdata) | $past(periph_en[7:0])))
    else $error("direction write not applied");
  AST_DATA_WRITE: assert property (wr && addr == 8'h00 |=> ((pin_out[7:0] ^ $past(wdata)) & ~$past(periph_en[7:0])) == '0)
    else $error("latch level not on pins");
  // Driven pins mask their group bit instead of excusing the whole port
  AST_PULL_GROUP: assert property (wr && addr == 8'h21 |=>
    pull_en[63:56] == ({{4{$past(wdata[7])}}, {4{$past(wdata[6])}}} &
    ~pin_oe[63:56]))
    else $error("pull group mismatch");
  cover property (wr && addr == 8'h17);
  cover property (rd && addr == 8'h01 && bus_8bit);
  cover property (|pull_en);
endmodule : pio_top_monitor
bind pio_top pio_top_monitor u_pio_top_monitor (.*);

// ### bench/pio_top_test.sv
// Self-checking bench for the programmable I/O port block
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end
module pio_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'h0, resetn = 1'h0, wr = 1'h0, rd = 1'h0, bus_8bit = 1'h0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, a, w, er;
  logic [1:0] proc_mode = 2'h0;
  logic [63:0] periph_en = '0, periph_dat = '0, ext_en = '0, ext_val = '0;
  logic [63:0] pin_in, pin_out, pin_oe, pull_en, eoe, eout, epull, pe;
  logic [7:0] lat [8], dr [8];
  logic [15:0] pl = '0;
  logic uprd = 1'h0, prot = 1'h0, m12;
  integer seed = 32'hc22a, err_count = 0, checks_done = 0, cyc, i, n, r, op;
  pio_top u_pio_top (.*);
  pio_pin_partner u_pio_pin_partner (.*);
  always #4 clk_sys = ~clk_sys;
  task test_done;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  initial begin
    #40000;
    err_count++;
    test_done;
  end
  initial begin
    lat = '{default: 8'h00};
    dr = '{default: 8'h00};
    repeat (8) @(posedge clk_sys);
    resetn <= 1'h1;
    for (cyc = 0; cyc < 3000; cyc++) begin
      @(posedge clk_sys);
      a = addr;
      w = wdata;
      pe = periph_en;
      m12 = proc_mode == 2'h1 || proc_mode == 2'h2;
      er = 8'h00;
      if (rd) begin
        case (a[7:3])
          5'h00: er = (dr[a[2:0]] & lat[a[2:0]]) | (~dr[a[2:0]] & pin_in[8*a[2:0] +: 8]);
          5'h02: er = dr[a[2:0]];
          5'h04: er = a[2] ? 8'h00 : a[1] ? {7'h00, a[0] ? prot : uprd} : a[0] ? pl[15:8] : pl[7:0];
          default: er = 8'h00;
        endcase
      end
      if (rd && a == 8'h01 && uprd && bus_8bit && m12) er = lat[1];
      if (wr && a[7:3] == 5'h00) lat[a[2:0]] = w;
      if (wr && a[7:3] == 5'h02 && (a[2:0] != 3'h7 || prot)) dr[a[2:0]] = w;
      if (wr && a == 8'h20) pl[7:0] = w;
      if (wr && a == 8'h21) pl[15:8] = w;
      if (wr && a == 8'h22) uprd = w[0];
      if (wr && a == 8'h23) prot = w[0];
      for (i = 0; i < 8; i++) begin
        eoe[8*i +: 8] = dr[i] | pe[8*i +: 8];
        eout[8*i +: 8] = (pe[8*i +: 8] & periph_dat[8*i +: 8]) | (~pe[8*i +: 8] & lat[i]);
        epull[8*i +: 8] = {{4{pl[2*i+1]}}, {4{pl[2*i]}}} & ~eoe[8*i +: 8];
        if (i < 6 && m12) epull[8*i +: 8] = 8'h00;
      end
      // A sweep of reads first visits every register; direction and control registers read their reset values, ports read their pins
      n = cyc < 21 ? cyc : $unsigned($random(seed)) % 21;
      op = cyc < 21 ? 1 : $random(seed) & 3;
      r = $random(seed);
      addr <= n < 16 ? {3'h0, n[3], 1'h0, n[2:0]} : n < 20 ? {6'h08, n[1:0]} : 8'h30;
      wdata <= (n == 18 || n == 19) ? {7'h00, r[0]} : r[7:0];
      wr <= op == 0;
      rd <= op == 1;
      proc_mode <= r[9:8];
      bus_8bit <= r[10];
      ext_val <= {$random(seed), $random(seed)};
      if (cyc % 64 == 63) begin
        periph_en <= {$random(seed), $random(seed)} & {$random(seed), $random(seed)};
        periph_dat <= {$random(seed), $random(seed)};
        ext_en <= {$random(seed), $random(seed)};
      end
      @(negedge clk_sys);
      `CHK("rdata", er, rdata)
      `CHK("pin_oe", eoe, pin_oe)
      `CHK("pin_out", eout, pin_out)
      `CHK("pull_en", epull, pull_en)
    end
    test_done;
  end
endmodule : pio_top_test

// ### src/pio_defs.svh
// Constants for the programmable I/O port block
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

`define PIO_NUM_PORTS 8
`define PIO_PORT_W 8
`define PIO_ADDR_W 8
`define PIO_PULL_W 16
`define PIO_GRP_W 4

`define PIO_GRP_DATA 4'h0
`define PIO_GRP_DIR 4'h1
`define PIO_GRP_CTL 4'h2
`define PIO_IDX_PULL0 4'h0
`define PIO_IDX_PULL1 4'h1
`define PIO_IDX_PCTL 4'h2
`define PIO_IDX_PROT 4'h3

`define PIO_UPPER_PORT 1
`define PIO_PROT_PORT 7
`define PIO_BUS_PORT_LAST 5

`define PIO_PCTL_UPRD 0
`define PIO_PROT_DIR 0

`define PIO_MODE_SINGLE 2'h0
`define PIO_MODE_MEMEXP 2'h1
`define PIO_MODE_MPU 2'h2

`define PIO_RST_BYTE 8'h00
`define PIO_RST_PULL 16'h0000

`endif

// ### src/pio_pkg.sv
// Types shared by the programmable I/O port block
`include "pio_defs.svh"
package pio_pkg;
  typedef logic [`PIO_PORT_W-1:0] pio_byte_t;

  typedef struct packed {
    pio_byte_t latch;
    pio_byte_t dir;
    pio_byte_t out;
    pio_byte_t oe;
    pio_byte_t pull;
  } pio_slice_st_t;

  typedef struct packed {
    logic [`PIO_PULL_W-1:0] pull;
    pio_byte_t pctl;
    pio_byte_t prot;
    pio_byte_t rdata;
  } pio_top_st_t;
endpackage : pio_pkg

// ### src/pio_port_slice.sv
// One eight-pin port: latch, direction, pin drive and pull-up
`include "pio_defs.svh"
module pio_port_slice (
  input wire logic clk_sys, // System clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic data_we, // Port register write
  input wire logic dir_we, // Direction register write, already permitted
  input wire logic [`PIO_PORT_W-1:0] wdata, // Write data
  input wire logic [`PIO_PORT_W-1:0] pin_in, // Pin levels
  input wire logic [1:0] pull_grp, // Pull-up group enables, high nibble in 1
  input wire logic pull_allow, // Pull-up bits honoured
  input wire logic latch_rd_all, // Read latch on every pin
  input wire logic [`PIO_PORT_W-1:0] periph_en, // Peripheral owns pin
  input wire logic [`PIO_PORT_W-1:0] periph_dat, // Peripheral level
  output logic [`PIO_PORT_W-1:0] rd_val, // Value a port read returns
  output logic [`PIO_PORT_W-1:0] dir_val, // Direction register contents
  output logic [`PIO_PORT_W-1:0] pin_out, // Pin output level
  output logic [`PIO_PORT_W-1:0] pin_oe, // Pin output enable
  output logic [`PIO_PORT_W-1:0] pull_en // Pull-up connect
);
  pio_pkg::pio_slice_st_t s;
  pio_pkg::pio_slice_st_t next_s;
  pio_pkg::pio_byte_t grp_mask;

  always_comb begin
    next_s = s;
    if (data_we) begin
      next_s.latch = wdata;
    end
    if (dir_we) begin
      next_s.dir = wdata;
    end
    next_s.out = (periph_en & periph_dat) | (~periph_en & next_s.latch);
    next_s.oe = next_s.dir | periph_en;
    grp_mask = {{`PIO_GRP_W{pull_grp[1]}}, {`PIO_GRP_W{pull_grp[0]}}};
    // A pin driven by a peripheral is an output, so it gets no pull-up
    next_s.pull = grp_mask & ~next_s.oe & {`PIO_PORT_W{pull_allow}};
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s <= '{`PIO_RST_BYTE, `PIO_RST_BYTE, `PIO_RST_BYTE, `PIO_RST_BYTE,
             `PIO_RST_BYTE};
    end else begin
      s <= next_s;
    end
  end

  // Output bits read the latch; input bits read the pin, or the latch when latch_rd_all is set
  assign rd_val = latch_rd_all ? s.latch :
                  ((s.dir & s.latch) | (~s.dir & pin_in));
  assign dir_val = s.dir;
  assign pin_out = s.out;
  assign pin_oe = s.oe;
  assign pull_en = s.pull;
endmodule : pio_port_slice

// ### src/pio_top.sv
// Programmable I/O port block: register port, eight ports of eight pins
`include "pio_defs.svh"
module pio_top (
  input wire logic clk_sys, // System clock, 125 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic [`PIO_ADDR_W-1:0] addr, // Register address
  input wire logic [`PIO_PORT_W-1:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [`PIO_PORT_W-1:0] rdata, // Read data, cycle after rd
  input wire logic [1:0] proc_mode, // Processor mode
  input wire logic bus_8bit, // External bus is 8 bits wide
  input wire logic [`PIO_NUM_PORTS*`PIO_PORT_W-1:0] pin_in, // Pin levels
  input wire logic [`PIO_NUM_PORTS*`PIO_PORT_W-1:0] periph_en, // Periph owns
  input wire logic [`PIO_NUM_PORTS*`PIO_PORT_W-1:0] periph_dat, // Periph lvl
  output logic [`PIO_NUM_PORTS*`PIO_PORT_W-1:0] pin_out, // Pin drive level
  output logic [`PIO_NUM_PORTS*`PIO_PORT_W-1:0] pin_oe, // Pin drive enable
  output logic [`PIO_NUM_PORTS*`PIO_PORT_W-1:0] pull_en // Pull-up connect
);
  localparam int NP = `PIO_NUM_PORTS;
  localparam int PW = `PIO_PORT_W;

  pio_pkg::pio_top_st_t s;
  pio_pkg::pio_top_st_t next_s;

  logic [3:0] a_grp;
  logic [3:0] a_idx;
  logic bus_mode;
  logic upper_latch_rd;
  logic [PW-1:0] rd_val [NP];
  logic [PW-1:0] dir_val [NP];

  assign a_grp = addr[7:4];
  assign a_idx = addr[3:0];
  assign bus_mode = (proc_mode == `PIO_MODE_MEMEXP) ||
                    (proc_mode == `PIO_MODE_MPU);
  // Select bit is dead unless the external bus is 8 bits wide
  assign upper_latch_rd = s.pctl[`PIO_PCTL_UPRD] & bus_8bit & bus_mode;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_port
      logic data_we;
      logic dir_we;
      logic dir_hit;
      logic pull_allow;
      logic latch_rd_all;

      assign data_we = wr && (a_grp == `PIO_GRP_DATA) &&
                       (a_idx == 4'(gi));
      assign dir_hit = wr && (a_grp == `PIO_GRP_DIR) && (a_idx == 4'(gi));
      if (gi == `PIO_PROT_PORT) begin : g_prot
        assign dir_we = dir_hit && s.prot[`PIO_PROT_DIR];
      end else begin : g_free
        assign dir_we = dir_hit;
      end
      if (gi <= `PIO_BUS_PORT_LAST) begin : g_bus
        assign pull_allow = !bus_mode;
      end else begin : g_nobus
        assign pull_allow = 1'b1;
      end
      if (gi == `PIO_UPPER_PORT) begin : g_upper
        assign latch_rd_all = upper_latch_rd;
      end else begin : g_plain
        assign latch_rd_all = 1'b0;
      end

      pio_port_slice u_slice (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .data_we(data_we),
        .dir_we(dir_we),
        .wdata(wdata),
        .pin_in(pin_in[gi*PW +: PW]),
        // Next pull bits, so a pull write lands on the pins at its own edge
        .pull_grp(next_s.pull[gi*2 +: 2]),
        .pull_allow(pull_allow),
        .latch_rd_all(latch_rd_all),
        .periph_en(periph_en[gi*PW +: PW]),
        .periph_dat(periph_dat[gi*PW +: PW]),
        .rd_val(rd_val[gi]),
        .dir_val(dir_val[gi]),
        .pin_out(pin_out[gi*PW +: PW]),
        .pin_oe(pin_oe[gi*PW +: PW]),
        .pull_en(pull_en[gi*PW +: PW])
      );
    end
  endgenerate

  always_comb begin
    next_s = s;
    next_s.rdata = `PIO_RST_BYTE;
    if (wr && (a_grp == `PIO_GRP_CTL)) begin
      case (a_idx)
        `PIO_IDX_PULL0: next_s.pull[PW-1:0] = wdata;
        `PIO_IDX_PULL1: next_s.pull[2*PW-1:PW] = wdata;
        `PIO_IDX_PCTL: next_s.pctl = wdata;
        `PIO_IDX_PROT: next_s.prot = wdata;
        default: next_s.pctl = s.pctl;
      endcase
    end
    // Read data stands one cycle only; unmapped addresses read zero
    if (rd) begin
      case (a_grp)
        `PIO_GRP_DATA: begin
          if (a_idx < 4'(NP)) begin
            next_s.rdata = rd_val[a_idx[2:0]];
          end
        end
        `PIO_GRP_DIR: begin
          if (a_idx < 4'(NP)) begin
            next_s.rdata = dir_val[a_idx[2:0]];
          end
        end
        `PIO_GRP_CTL: begin
          case (a_idx)
            `PIO_IDX_PULL0: next_s.rdata = s.pull[PW-1:0];
            `PIO_IDX_PULL1: next_s.rdata = s.pull[2*PW-1:PW];
            `PIO_IDX_PCTL: next_s.rdata = s.pctl;
            `PIO_IDX_PROT: next_s.rdata = s.prot;
            default: next_s.rdata = `PIO_RST_BYTE;
          endcase
        end
        default: next_s.rdata = `PIO_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s <= '{`PIO_RST_PULL, `PIO_RST_BYTE, `PIO_RST_BYTE, `PIO_RST_BYTE};
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
endmodule : pio_top
